// >>> logic/link_rate_div.v
// Divides the system crystal clock into link timing ticks.
// Assumes the rate code is stable once written.
`timescale 1ns/10ps
`default_nettype none
module link_rate_div
(
  input  wire       clk,
  input  wire       rst,
  input  wire       run,
  input  wire [1:0] rate,
  output reg        tick
);
  reg  [2:0] cnt_q;
  wire [2:0] last;

  // Code 0..3 gives divide by 1, 2, 4, 8
  assign last = (3'h1 << rate) - 3'h1;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 3'h0;
      tick  <= 1'b0;
    end
    else if (!run)
    begin
      // Frozen while clocks are stopped in wait mode
      tick <= 1'b0;
    end
    else if (cnt_q >= last)
    begin
      cnt_q <= 3'h0;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 3'h1;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> logic/vpw_link_controller.v
// Error handling and first control register of a VPW serial link controller.
// Assumes a symbol decoder supplies one-cycle symbol pulses in the clk domain.
`timescale 1ns/10ps
`default_nettype none
`include "vpw_link_defs.vh"

module vpw_link_controller
(
  input  wire        clk,
  input  wire        rst,
  // AXI4-Lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Symbol decoder and protocol engine
  input  wire        sym_sof,
  input  wire        sym_eod,
  input  wire        sym_eof,
  input  wire        sym_break,
  input  wire        sym_invalid,
  input  wire        byte_boundary,
  input  wire        crc_fail,
  input  wire        tx_request,
  input  wire        tx_no_echo,
  input  wire        bus_idle,
  input  wire        bus_stuck_dominant,
  input  wire        arb_lost,
  input  wire        bus_wake_edge,
  input  wire        cpu_wait,
  output wire        tx_enable,
  output reg         tx_abort,
  output wire        rx_enable,
  output wire        timing_base_sel,
  output wire        link_tick,
  output wire        clk_run,
  output wire        irq
);
  // ==========================================================
  // Registers
  reg        ignore_frame_q;
  reg        timing_base_select_q;
  reg  [1:0] rate_sel_q;
  reg        rate_locked_q;
  reg        irq_enable_q;
  reg        wait_clock_gate_q;
  reg  [2:0] state_q;
  reg  [2:0] state_d;
  reg        flag_inv_q;
  reg        flag_crc_q;
  reg        flag_loa_q;
  reg        flag_wake_q;
  reg        stuck_q;
  reg  [7:0] vector;
  wire [7:0] ctrl_rd;
  wire       wr_go;
  wire       wr_ctrl;
  wire       rd_go;
  wire       rd_vec;
  wire       run;
  wire       in_tx;
  wire       in_rx;
  wire       off_bound;
  wire       tx_err;
  wire       rx_frame_err;
  wire       crc_err;
  wire       stuck_rise;
  wire       hold;
  wire       set_inv;
  wire       set_crc;
  wire       set_loa;
  wire       clr_inv;
  wire       clr_crc;
  wire       clr_loa;
  wire       clr_wake;

  // ==========================================================
  // Bus slave
  // Address and data are taken together, so either arrival order works
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign wr_ctrl       = wr_go & ({s_axi_awaddr[3:2], 2'h0} == `ADDR_LINK_CONTROL_ONE) & s_axi_wstrb[0];
  assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_vec        = rd_go & ({s_axi_araddr[3:2], 2'h0} == `ADDR_LINK_STATE_VECTOR);

  assign ctrl_rd = {ignore_frame_q, timing_base_select_q, rate_sel_q, 2'h0, irq_enable_q, wait_clock_gate_q};

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h0;
    end
    else
    begin
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= ({s_axi_awaddr[3:2], 2'h0} <= `ADDR_LINK_STATE_VECTOR) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr[3:2])
          2'h0: s_axi_rdata <= {24'h0, ctrl_rd};
          2'h1: s_axi_rdata <= {24'h0, vector};
          default:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Control register
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ignore_frame_q       <= 1'b0;
      timing_base_select_q <= 1'b0;
      rate_sel_q           <= 2'h0;
      rate_locked_q        <= 1'b0;
      irq_enable_q         <= 1'b0;
      wait_clock_gate_q    <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        timing_base_select_q <= s_axi_wdata[`BIT_TIMING_BASE_SELECT];
        irq_enable_q         <= s_axi_wdata[`BIT_IRQ_ENABLE];
        wait_clock_gate_q    <= s_axi_wdata[`BIT_WAIT_CLOCK_GATE];
        if (!rate_locked_q)
        begin
          rate_sel_q    <= {s_axi_wdata[`BIT_RATE_SEL_HI], s_axi_wdata[`BIT_RATE_SEL_LO]};
          rate_locked_q <= 1'b1;
        end
      end
      // Hardware clear wins over a software set in the same cycle
      if (sym_sof | sym_break)
        ignore_frame_q <= 1'b0;
      else if (wr_ctrl)
        ignore_frame_q <= s_axi_wdata[`BIT_IGNORE_FRAME];
    end
  end

  assign timing_base_sel = timing_base_select_q;
  assign clk_run         = ~(cpu_wait & wait_clock_gate_q);
  assign run             = clk_run;

  link_rate_div u_div
  (
    .clk  (clk),
    .rst  (rst),
    .run  (run),
    .rate (rate_sel_q),
    .tick (link_tick)
  );

  // ==========================================================
  // Error detection
  assign in_tx        = (state_q == `ST_TX);
  assign in_rx        = (state_q == `ST_RX);
  assign off_bound    = (sym_eod | sym_eof) & ~byte_boundary;
  assign tx_err       = in_tx & (sym_invalid | off_bound | tx_no_echo);
  assign rx_frame_err = in_rx & (off_bound | sym_invalid);
  assign crc_err      = in_rx & crc_fail;
  assign stuck_rise   = bus_stuck_dominant & ~stuck_q;
  assign hold         = ignore_frame_q & ~sym_break;

  // ==========================================================
  // Link state
  always @*
  begin
    state_d = state_q;
    case (state_q)
      `ST_IDLE:
      begin
        if (sym_sof)
          state_d = `ST_RX;
        else if (tx_request & bus_idle & ~bus_stuck_dominant & ~ignore_frame_q)
          state_d = `ST_TX;
      end
      `ST_RX:
      begin
        if (sym_eof & byte_boundary)
          state_d = `ST_IDLE;
      end
      `ST_TX:
      begin
        if (sym_eof & byte_boundary)
          state_d = `ST_IDLE;
      end
      `ST_WAIT_EOF:
      begin
        if (sym_eof)
          state_d = `ST_IDLE;
      end
      `ST_WAIT_SOF:
      begin
        if (sym_sof)
          state_d = `ST_RX;
      end
      default: state_d = `ST_IDLE;
    endcase
    if (tx_err | rx_frame_err | crc_err | stuck_rise)
      state_d = `ST_WAIT_EOF;
    if (wr_ctrl & s_axi_wdata[`BIT_IGNORE_FRAME] & in_rx & ~sym_sof)
      state_d = `ST_WAIT_SOF;
    if (sym_break)
      state_d = `ST_WAIT_SOF;
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q  <= `ST_IDLE;
      stuck_q  <= 1'b0;
      tx_abort <= 1'b0;
    end
    else if (run)
    begin
      state_q  <= state_d;
      stuck_q  <= bus_stuck_dominant;
      tx_abort <= tx_err | (in_tx & sym_break);
    end
    else
      tx_abort <= 1'b0;
  end

  // Transmit never driven with a stuck bus
  assign tx_enable = in_tx & ~bus_stuck_dominant;
  assign rx_enable = ~ignore_frame_q & (state_q != `ST_WAIT_SOF);

  // ==========================================================
  // Status flags and state vector
  assign set_inv  = tx_err | rx_frame_err | stuck_rise | sym_break;
  assign set_crc  = crc_err;
  assign set_loa  = arb_lost & (in_tx | bus_stuck_dominant);
  assign clr_inv  = rd_vec & (vector == `SV_INVALID_SYMBOL);
  assign clr_crc  = rd_vec & (vector == `SV_CRC_ERROR);
  assign clr_loa  = rd_vec & (vector == `SV_ARB_LOST);
  assign clr_wake = rd_vec & (vector == `SV_WAKEUP);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flag_inv_q  <= 1'b0;
      flag_crc_q  <= 1'b0;
      flag_loa_q  <= 1'b0;
      flag_wake_q <= 1'b0;
    end
    else
    begin
      // Set wins over a clearing read in the same cycle
      if (hold)
      begin
        flag_inv_q <= 1'b0;
        flag_crc_q <= 1'b0;
        flag_loa_q <= 1'b0;
      end
      else
      begin
        flag_inv_q <= set_inv | (flag_inv_q & ~clr_inv);
        flag_crc_q <= set_crc | (flag_crc_q & ~clr_crc);
        flag_loa_q <= set_loa | (flag_loa_q & ~clr_loa);
      end
      flag_wake_q <= (bus_wake_edge & cpu_wait) | (flag_wake_q & ~clr_wake);
    end
  end

  always @*
  begin
    if (flag_inv_q)
      vector = `SV_INVALID_SYMBOL;
    else if (flag_crc_q)
      vector = `SV_CRC_ERROR;
    else if (flag_loa_q)
      vector = `SV_ARB_LOST;
    else if (flag_wake_q)
      vector = `SV_WAKEUP;
    else
      vector = `SV_NONE;
  end

  // Wakeup passes the ignore mask; others need enable and no ignore
  assign irq = (vector == `SV_WAKEUP) |
               (irq_enable_q & ~ignore_frame_q & (vector != `SV_NONE));
endmodule
`default_nettype wire

// >>> logic/vpw_link_defs.vh
// Constants for the VPW link error and control block.
// Assumes inclusion by bare name from the design files.
`ifndef VPW_LINK_DEFS_VH
`define VPW_LINK_DEFS_VH

// ==========================================================
// Register byte addresses
`define ADDR_LINK_CONTROL_ONE 4'h0
`define ADDR_LINK_STATE_VECTOR 4'h4

// ==========================================================
// Control register fields
`define BIT_IGNORE_FRAME 7
`define BIT_TIMING_BASE_SELECT 6
`define BIT_RATE_SEL_HI 5
`define BIT_RATE_SEL_LO 4
`define BIT_IRQ_ENABLE 1
`define BIT_WAIT_CLOCK_GATE 0
`define CTRL_RESET 8'h00

// ==========================================================
// State vector codes: no-flag code, then the flag codes highest priority first
`define SV_NONE 8'h00
`define SV_INVALID_SYMBOL 8'h1c
`define SV_CRC_ERROR 8'h18
`define SV_ARB_LOST 8'h14
`define SV_WAKEUP 8'h20

// ==========================================================
// Link states
`define ST_IDLE 3'h0
`define ST_RX 3'h1
`define ST_TX 3'h2
`define ST_WAIT_EOF 3'h3
`define ST_WAIT_SOF 3'h4

// ==========================================================
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> testbench/bus_node_model.sv
// Far-side node model: one-cycle symbol and fault events.
// Assumes the caller enters just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module bus_node_model
(
  input  wire logic       clk,
  output var  logic [8:0] ev
);
  // ==========================================================
  // Events
  initial ev = 9'h000;
  // Released lines sit low, as the decoder idles
  task automatic pulse(input int idx);
    ev <= 9'h001 << idx;
    @(posedge clk);
    ev <= 9'h000;
  endtask
endmodule
`default_nettype wire

// >>> testbench/link_checker.sv
// Concurrent checks on the VPW link controller ports.
// Assumes it is bound into the controller, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module link_checker
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       sym_sof,
  input wire logic       sym_break,
  input wire logic       sym_invalid,
  input wire logic       bus_stuck_dominant,
  input wire logic       cpu_wait,
  input wire logic       clk_run,
  input wire logic       tx_enable,
  input wire logic       tx_abort,
  input wire logic       rx_enable,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid
);
  // ==========================================================
  // Link rules
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_abort_on_noise:
  assert property (tx_enable && sym_invalid && clk_run |=> tx_abort) else $error("abort missing");
  chk_tx_stops:
  assert property (tx_enable && sym_invalid && clk_run |=> !tx_enable) else $error("transmit kept on");
  chk_break_waits_sof:
  assert property (sym_break && clk_run |=> !rx_enable) else $error("receiver live after break");
  chk_sof_enables_rx:
  assert property (sym_sof && !sym_break && clk_run |=> rx_enable) else $error("receiver off after sof");
  chk_no_tx_stuck:
  assert property (bus_stuck_dominant && clk_run |=> !tx_enable) else $error("transmit on stuck bus");
  chk_clock_runs:
  assert property (!cpu_wait |-> clk_run) else $error("clock stopped out of wait");
  // ==========================================================
  // Register bus checks and link cover points
  chk_bresp_stands:
  assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  cov_abort: cover property (tx_abort);
  cov_break: cover property (sym_break && clk_run);
  cov_gated: cover property (!clk_run);
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the VPW link error and control block.
// Assumes the node model and checker files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ==========================================================
  // Signals
  localparam int SOF = 0, EOFS = 1, BRK = 2, INV = 3, CRC = 4, ECHO = 5, EOD = 6, ARB = 7, WAKE = 8;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  aw_addr = 4'h0;
  logic [3:0]  ar_addr = 4'h0;
  logic [31:0] w_data = 32'h0;
  logic        aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
  logic        tx_req = 1'b0, idle = 1'b1, stuck = 1'b0, cpu_wait = 1'b0, bnd = 1'b1;
  logic [1:0]  resp_v;
  wire         aw_ready, w_ready, b_valid, ar_ready, r_valid, tx_en, tx_abort, rx_en, tbs, tick, clk_run, irq;
  wire  [1:0]  b_resp, r_resp;
  wire  [31:0] r_data;
  wire  [8:0]  ev;
  int          num_errors = 0;
  int          comparisons = 0;
  always #4 clk = ~clk;
  bus_node_model i_node (.clk(clk), .ev(ev));
  vpw_link_controller i_dut
  (
    .clk(clk), .rst(rst), .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
    .s_axi_wdata(w_data), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid), .s_axi_bready(b_ready), .s_axi_araddr(ar_addr),
    .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready), .s_axi_rdata(r_data), .s_axi_rresp(r_resp),
    .s_axi_rvalid(r_valid), .s_axi_rready(r_ready), .sym_sof(ev[0]), .sym_eof(ev[1]), .sym_break(ev[2]),
    .sym_invalid(ev[3]), .crc_fail(ev[4]), .tx_no_echo(ev[5]), .sym_eod(ev[6]), .arb_lost(ev[7]),
    .bus_wake_edge(ev[8]), .byte_boundary(bnd), .tx_request(tx_req), .bus_idle(idle),
    .bus_stuck_dominant(stuck), .cpu_wait(cpu_wait), .tx_enable(tx_en), .tx_abort(tx_abort),
    .rx_enable(rx_en), .timing_base_sel(tbs), .link_tick(tick), .clk_run(clk_run), .irq(irq)
  );
  // ==========================================================
  // Helpers
  function automatic logic [31:0] b(input logic x);
    return {31'h0, x};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    do @(posedge clk); while (aw_ready !== 1'b1);
    aw_valid <= 1'b0;
    w_valid <= 1'b0;
    b_ready <= 1'b1;
    do @(posedge clk); while (b_valid !== 1'b1);
    resp_v = b_resp;
    b_ready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    ar_addr <= a;
    ar_valid <= 1'b1;
    do @(posedge clk); while (ar_ready !== 1'b1);
    ar_valid <= 1'b0;
    r_ready <= 1'b1;
    do @(posedge clk); while (r_valid !== 1'b1);
    r_ready <= 1'b0;
    resp_v = r_resp;
    check(r_data, exp);
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    int n;
    n = 0;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    wr(4'h0, 32'h72);
    rd(4'h0, 32'h72);
    check(b(tbs), 32'h1);
    wr(4'h0, 32'h02);
    rd(4'h0, 32'h32);
    check(b(tbs), 32'h0);
    rd(4'h8, 32'h0);
    check({30'h0, resp_v}, 32'h2);
    wr(4'h8, 32'h5a);
    check({30'h0, resp_v}, 32'h2);
    // Rate code 11 locked in: one tick every 8 cycles
    repeat (64)
    begin
      @(posedge clk);
      n = n + tick;
    end
    check(n, 32'd8);
    $display("register test done");
  endtask
  task automatic t_tx();
    tx_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(b(tx_en), 32'h1);
    @(posedge clk);
    i_node.pulse(INV);
    #1;
    check(b(tx_en), 32'h0);
    check(b(tx_abort), 32'h1);
    check(b(irq), 32'h1);
    @(posedge clk);
    tx_req <= 1'b0;
    rd(4'h4, 32'h1c);
    #1;
    check(b(irq), 32'h0);
    @(posedge clk);
    i_node.pulse(EOFS);
    wr(4'h0, 32'h00);
    // CRC is only judged inside a received frame
    i_node.pulse(SOF);
    @(posedge clk);
    i_node.pulse(CRC);
    #1;
    check(b(irq), 32'h0);
    @(posedge clk);
    rd(4'h4, 32'h18);
    $display("transmit and crc test done");
  endtask
  task automatic t_ignore();
    wr(4'h0, 32'h82);
    #1;
    check(b(rx_en), 32'h0);
    @(posedge clk);
    stuck <= 1'b1;
    @(posedge clk);
    stuck <= 1'b0;
    #1;
    check(b(irq), 32'h0);
    @(posedge clk);
    rd(4'h4, 32'h0);
    i_node.pulse(BRK);
    #1;
    check(b(rx_en), 32'h0);
    check(b(irq), 32'h1);
    @(posedge clk);
    rd(4'h0, 32'h32);
    rd(4'h4, 32'h1c);
    #1;
    check(b(irq), 32'h0);
    @(posedge clk);
    i_node.pulse(SOF);
    #1;
    check(b(rx_en), 32'h1);
    @(posedge clk);
    wr(4'h0, 32'h82);
    #1;
    check(b(rx_en), 32'h0);
    @(posedge clk);
    i_node.pulse(SOF);
    @(posedge clk);
    bnd <= 1'b0;
    i_node.pulse(EOD);
    bnd <= 1'b1;
    #1;
    check(b(irq), 32'h1);
    @(posedge clk);
    rd(4'h4, 32'h1c);
    i_node.pulse(EOFS);
    $display("ignore test done");
  endtask
  task automatic t_fault();
    stuck <= 1'b1;
    idle <= 1'b0;
    tx_req <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(b(tx_en), 32'h0);
    @(posedge clk);
    i_node.pulse(ARB);
    stuck <= 1'b0;
    idle <= 1'b1;
    rd(4'h4, 32'h1c);
    rd(4'h4, 32'h14);
    #1;
    check(b(tx_en), 32'h0);
    @(posedge clk);
    i_node.pulse(EOFS);
    @(posedge clk);
    #1;
    check(b(tx_en), 32'h1);
    @(posedge clk);
    i_node.pulse(ECHO);
    #1;
    check(b(tx_en), 32'h0);
    @(posedge clk);
    tx_req <= 1'b0;
    rd(4'h4, 32'h1c);
    i_node.pulse(EOFS);
    // Ignore set and enable off: only the wakeup may get through
    wr(4'h0, 32'h81);
    cpu_wait <= 1'b1;
    @(posedge clk);
    #1;
    check(b(clk_run), 32'h0);
    @(posedge clk);
    i_node.pulse(WAKE);
    #1;
    check(b(irq), 32'h1);
    @(posedge clk);
    rd(4'h4, 32'h20);
    wr(4'h0, 32'h02);
    #1;
    check(b(clk_run), 32'h1);
    $display("fault and wait test done");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_tx();
    t_ignore();
    t_fault();
    finish_test();
  end
  initial
  begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule
bind vpw_link_controller link_checker i_chk
(
  .clk(clk), .rst(rst), .sym_sof(sym_sof), .sym_break(sym_break), .sym_invalid(sym_invalid),
  .bus_stuck_dominant(bus_stuck_dominant), .cpu_wait(cpu_wait), .clk_run(clk_run), .tx_enable(tx_enable),
  .tx_abort(tx_abort), .rx_enable(rx_enable), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire
